// ### pkg/rwt_pkg.sv
// constants and types shared by the read/write turnaround timer
package rwt_pkg;
   localparam int unsigned LAT_W = 6;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned BG_W = 2;
   localparam int unsigned WTR_W = 4;
   localparam int unsigned DRIVE_PIPE_DEPTH = 80;
   localparam logic [CNT_W-1:0] BURST_EIGHT = 8'h08;
   localparam logic [CNT_W-1:0] BURST_CHOP_FOUR = 8'h04;
   localparam logic [CNT_W-1:0] ONE_CK = 8'h01;
   localparam logic [CNT_W-1:0] PREAMBLE_ONE_CK = 8'h01;
   localparam logic [CNT_W-1:0] PREAMBLE_TWO_CK = 8'h02;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam logic [7:0] EIGHT_DRIVE_MASK = 8'h0f;
   localparam logic [7:0] CHOP_DRIVE_MASK = 8'h03;
   typedef enum logic [1:0]
   {
      RWT_BURST_FIXED_EIGHT = 2'b00,
      RWT_BURST_ON_THE_FLY = 2'b01,
      RWT_BURST_FIXED_CHOP = 2'b10
   } rwt_burst_mode_t;
endpackage

// ### pkg/rwt_rd_if.sv
// read launch and data drive window between the timer and its drive window
`timescale 1ns/10ps
interface rwt_rd_if;
   import rwt_pkg::*;
   logic launch;
   logic chop;
   logic [LAT_W-1:0] read_latency;
   logic drive;
   modport ctrl (output launch, output chop, output read_latency, input drive);
   modport win (input launch, input chop, input read_latency, output drive);
endinterface

// ### rtl/rwt_read_window.sv
// read data drive window: starts at read_latency, holds four or two clocks
`timescale 1ns/10ps
module rwt_read_window
   import rwt_pkg::*;
#(
   parameter int unsigned DEPTH = DRIVE_PIPE_DEPTH
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   rwt_rd_if.win rd
);
   logic [DEPTH-1:0] pipe;
   logic [CNT_W-1:0] since_launch;
   logic [LAT_W-1:0] rl_cap;
   logic chop_cap;
   logic lone;

   function automatic logic [DEPTH-1:0] window_mask(input logic [LAT_W-1:0] rl,
                                                    input logic chop);
      logic [DEPTH-1:0] beats;
      beats = chop ? DEPTH'(CHOP_DRIVE_MASK) : DEPTH'(EIGHT_DRIVE_MASK);
      return beats << rl;
   endfunction

   // one bit per future clock; overlapping bursts simply merge
   // drive from read_latency
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pipe <= '0;
      else
         pipe <= (pipe >> 1) | (rd.launch ? window_mask(rd.read_latency, rd.chop) : '0);
   end

   assign rd.drive = pipe[0];

   // helper state for the checks below
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         since_launch <= CNT_MAX;
         rl_cap <= '0;
         chop_cap <= 1'b0;
         lone <= 1'b1;
      end
      else if (rd.launch)
      begin
         // a read issued while an earlier window is pending gets no start or release time check
         lone <= (since_launch > CNT_W'(rl_cap) + 8'h05);
         since_launch <= ONE_CK;
         rl_cap <= rd.read_latency;
         chop_cap <= rd.chop;
      end
      else if (since_launch != CNT_MAX)
         since_launch <= since_launch + ONE_CK;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_drive_starts;
      $rose(rd.drive);
   endsequence

   chk_drive_start_latency: assert property (s_drive_starts ##0 lone |->
      since_launch == CNT_W'(rl_cap) + ONE_CK)
      else $error("read drive did not start at read latency");
   chk_drive_eight_hold: assert property (s_drive_starts and !chop_cap |->
      rd.drive [*4])
      else $error("eight beat drive shorter than four clocks");
   chk_drive_chop_hold: assert property (s_drive_starts and chop_cap |->
      rd.drive [*2])
      else $error("chop drive shorter than two clocks");
   chk_drive_end_time: assert property ($fell(rd.drive) && lone |->
      since_launch == CNT_W'(rl_cap) + ONE_CK + (chop_cap ? 8'h02 : 8'h04))
      else $error("read drive released at wrong clock");
endmodule // rwt_read_window

// ### rtl/rwt_turnaround_timer.sv
// read/write turnaround checker and read drive window of the dram core
`timescale 1ns/10ps
module rwt_turnaround_timer
   import rwt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic dll_enabled,
   input wire logic dll_locked,
   input wire logic zq_extended_applied,
   input wire logic [1:0] burst_mode,
   input wire logic [LAT_W-1:0] cas_latency,
   input wire logic [LAT_W-1:0] write_cas_latency,
   input wire logic write_preamble_two_ck,
   input wire logic [WTR_W-1:0] write_to_read_long,
   input wire logic [WTR_W-1:0] write_to_read_short,
   input wire logic cmd_read,
   input wire logic cmd_write,
   input wire logic [BG_W-1:0] cmd_bank_group,
   input wire logic cmd_a12,
   output logic read_drive_en,
   output logic read_chop_active,
   output logic rd_to_wr_early,
   output logic wr_to_rd_early
);
   rwt_rd_if rd ();

   logic normal_op;
   logic checks_on;
   logic read_is_chop;
   logic [CNT_W-1:0] rd_half;
   logic [CNT_W-1:0] wr_half;
   logic [CNT_W-1:0] wpre;
   logic [CNT_W-1:0] since_read;
   logic [CNT_W-1:0] since_write;
   logic seen_read;
   logic seen_write;
   logic [CNT_W-1:0] last_rd_half;
   logic [CNT_W-1:0] last_wr_half;
   logic [BG_W-1:0] last_wr_group;
   logic [CNT_W-1:0] wtr_pick;
   logic next_rd_to_wr_early;
   logic next_wr_to_rd_early;

   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c);
      return (c == CNT_MAX) ? c : c + ONE_CK;
   endfunction

   // one spare bit so a saturated counter plus latency cannot wrap
   function automatic logic [CNT_W:0] wide(input logic [CNT_W-1:0] v);
      return {1'b0, v};
   endfunction

   assign normal_op = dll_enabled & dll_locked;
   assign checks_on = normal_op & zq_extended_applied;

   // read length, a12 on the fly
   assign read_is_chop = (burst_mode == RWT_BURST_FIXED_CHOP)
                       | ((burst_mode == RWT_BURST_ON_THE_FLY) & ~cmd_a12);
   assign rd_half = (read_is_chop ? BURST_CHOP_FOUR : BURST_EIGHT) >> 1;
   assign wr_half = ((burst_mode == RWT_BURST_FIXED_CHOP) ? BURST_CHOP_FOUR : BURST_EIGHT) >> 1;
   assign wpre = write_preamble_two_ck ? PREAMBLE_TWO_CK : PREAMBLE_ONE_CK;

   assign rd.launch = cmd_read;
   assign rd.chop = read_is_chop;
   assign rd.read_latency = cas_latency;

   rwt_read_window #(.DEPTH(DRIVE_PIPE_DEPTH)) u_window
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rd(rd)
   );

   // last read and write kept for spacing
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         since_read <= CNT_MAX;
         seen_read <= 1'b0;
         last_rd_half <= BURST_EIGHT >> 1;
      end
      else if (cmd_read)
      begin
         since_read <= '0;
         seen_read <= 1'b1;
         last_rd_half <= rd_half;
      end
      else
         since_read <= bump(since_read);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         since_write <= CNT_MAX;
         seen_write <= 1'b0;
         last_wr_half <= BURST_EIGHT >> 1;
         last_wr_group <= '0;
      end
      else if (cmd_write)
      begin
         since_write <= '0;
         seen_write <= 1'b1;
         last_wr_half <= wr_half;
         last_wr_group <= cmd_bank_group;
      end
      else
         since_write <= bump(since_write);
   end

   // same group long delay, other group short
   assign wtr_pick = (cmd_bank_group == last_wr_group) ? CNT_W'(write_to_read_long)
                                                       : CNT_W'(write_to_read_short);

   always_comb
   begin
      // distance in clocks is counter plus one; latencies moved across to stay unsigned
      // a counter parked at its ceiling must never look like a short distance
      // read to write, any group
      next_rd_to_wr_early = checks_on & cmd_write & seen_read
         & ((wide(since_read) + wide(CNT_W'(write_cas_latency)))
            < (wide(CNT_W'(cas_latency)) + wide(last_rd_half) + wide(wpre)));
      next_wr_to_rd_early = checks_on & cmd_read & seen_write
         & ((wide(since_write) + wide(ONE_CK))
            < (wide(CNT_W'(write_cas_latency)) + wide(last_wr_half) + wide(wtr_pick)));
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_to_wr_early <= 1'b0;
         wr_to_rd_early <= 1'b0;
      end
      else
      begin
         rd_to_wr_early <= next_rd_to_wr_early;
         wr_to_rd_early <= next_wr_to_rd_early;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         read_drive_en <= 1'b0;
         read_chop_active <= 1'b0;
      end
      else
      begin
         read_drive_en <= rd.drive;
         if (cmd_read)
            read_chop_active <= read_is_chop;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_read_then_write;
      cmd_read ##1 cmd_write;
   endsequence

   chk_abnormal_silent: assert property (!normal_op |=>
      !rd_to_wr_early && !wr_to_rd_early)
      else $error("spacing flag raised outside normal operation");
   chk_zq_gate_silent: assert property (!zq_extended_applied |=>
      !rd_to_wr_early && !wr_to_rd_early)
      else $error("spacing flag raised without extended calibration");
   chk_rw_adjacent_early: assert property (
      s_read_then_write ##0 (checks_on && cas_latency >= write_cas_latency)
      |=> rd_to_wr_early)
      else $error("write one clock after read not flagged");
   chk_rw_far_ok: assert property (
      cmd_write && !cmd_read && since_read == CNT_MAX |=> !rd_to_wr_early)
      else $error("distant write wrongly flagged");
   chk_wr_same_group: assert property (
      checks_on && cmd_read && seen_write && cmd_bank_group == last_wr_group
      && wide(since_write) + wide(ONE_CK)
         < wide(CNT_W'(write_cas_latency)) + wide(last_wr_half)
      |=> wr_to_rd_early)
      else $error("early same group read not flagged");
   chk_wr_other_short: assert property (
      checks_on && cmd_read && seen_write && cmd_bank_group != last_wr_group
      && wide(since_write) + wide(ONE_CK) >= wide(CNT_W'(write_cas_latency))
         + wide(last_wr_half) + wide(CNT_W'(write_to_read_short))
      |=> !wr_to_rd_early)
      else $error("other group read flagged despite short delay met");
   chk_otf_a12_length: assert property (
      cmd_read && burst_mode == RWT_BURST_ON_THE_FLY |=> read_chop_active == !$past(cmd_a12))
      else $error("on the fly length not taken from a12");
   chk_drive_follows: assert property (rd.drive |=> read_drive_en)
      else $error("drive enable not passed out");
endmodule // rwt_turnaround_timer

// ### verif/rwt_ctrl_model.sv
// memory controller model: issues read and write commands on the command clock
`timescale 1ns/10ps
module rwt_ctrl_model
   import rwt_pkg::*;
(
   input wire logic clk_sys,
   output logic cmd_read,
   output logic cmd_write,
   output logic [BG_W-1:0] cmd_bank_group,
   output logic cmd_a12
);
   initial
   begin
      cmd_read = 1'b0;
      cmd_write = 1'b0;
      cmd_bank_group = '0;
      cmd_a12 = 1'b0;
   end
   // spacing set by caller
   // group and a12 are inverted once stale, so the core cannot lean on old bits
   task automatic send(input logic rd, input logic wr, input logic [BG_W-1:0] bg,
                       input logic a12);
      @(negedge clk_sys);
      cmd_read = rd;
      cmd_write = wr;
      cmd_bank_group = bg;
      cmd_a12 = a12;
      @(negedge clk_sys);
      cmd_read = 1'b0;
      cmd_write = 1'b0;
      cmd_bank_group = ~bg;
      cmd_a12 = ~a12;
   endtask
   // back to back commands, the second one clock after the first
   task automatic send_pair(input logic rd, input logic [BG_W-1:0] bg0,
                            input logic [BG_W-1:0] bg1, input logic a0, input logic a1);
      @(negedge clk_sys);
      cmd_read = rd;
      cmd_write = !rd;
      cmd_bank_group = bg0;
      cmd_a12 = a0;
      @(negedge clk_sys);
      cmd_read = !rd;
      cmd_write = rd;
      cmd_bank_group = bg1;
      cmd_a12 = a1;
      @(negedge clk_sys);
      cmd_read = 1'b0;
      cmd_write = 1'b0;
      cmd_bank_group = ~bg1;
      cmd_a12 = ~a1;
   endtask
endmodule // rwt_ctrl_model

// ### verif/rwt_turnaround_timer_test.sv
// self-checking bench for the read/write turnaround timer
`timescale 1ns/10ps
module rwt_turnaround_timer_test;
   import rwt_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic dll_enabled = 1'b1;
   logic dll_locked = 1'b1;
   logic zq_extended_applied = 1'b1;
   logic [1:0] burst_mode = 2'b00;
   logic [LAT_W-1:0] cas_latency = 6'h0b;
   logic [LAT_W-1:0] write_cas_latency = 6'h09;
   logic write_preamble_two_ck = 1'b0;
   logic [WTR_W-1:0] write_to_read_long = 4'h4;
   logic [WTR_W-1:0] write_to_read_short = 4'h2;
   logic cmd_read, cmd_write, cmd_a12;
   logic [BG_W-1:0] cmd_bank_group;
   logic read_drive_en, read_chop_active, rd_to_wr_early, wr_to_rd_early;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   always #2.5 clk_sys = ~clk_sys;

   rwt_ctrl_model rwt_ctrl_model_inst (.clk_sys(clk_sys), .cmd_read(cmd_read),
      .cmd_write(cmd_write), .cmd_bank_group(cmd_bank_group), .cmd_a12(cmd_a12));

   rwt_turnaround_timer rwt_turnaround_timer_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .dll_enabled(dll_enabled), .dll_locked(dll_locked),
      .zq_extended_applied(zq_extended_applied), .burst_mode(burst_mode),
      .cas_latency(cas_latency), .write_cas_latency(write_cas_latency),
      .write_preamble_two_ck(write_preamble_two_ck),
      .write_to_read_long(write_to_read_long), .write_to_read_short(write_to_read_short),
      .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_bank_group(cmd_bank_group),
      .cmd_a12(cmd_a12), .read_drive_en(read_drive_en), .read_chop_active(read_chop_active),
      .rd_to_wr_early(rd_to_wr_early), .wr_to_rd_early(wr_to_rd_early));

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // a hang costs one mismatch and ends the run
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         fail_count++;
         close_out();
      end
   end

   task automatic check(input string what, input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %0b seen %0b", what, exp, seen);
      end
   endtask

   function automatic int read_burst_len(input logic [1:0] m, input logic a);
      return (m == 2'b10 || (m == 2'b01 && !a)) ? 4 : 8;
   endfunction

   function automatic int write_burst_len(input logic [1:0] m);
      return (m == 2'b10) ? 4 : 8;
   endfunction

   // each scenario starts from an empty command history
   task automatic do_reset();
      @(negedge clk_sys);
      rst_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
   endtask

   task automatic read_window(input logic a);
      int rl;
      int len;
      do_reset();
      rl = int'(cas_latency);
      len = read_burst_len(burst_mode, a) / 2;
      rwt_ctrl_model_inst.send(1'b1, 1'b0, 2'b00, a);
      for (int k = 1; k <= rl + 6; k++)
      begin
         @(negedge clk_sys);
         check("read_drive_en", read_drive_en, k > rl && k <= rl + len);
      end
      check("read_chop_active", read_chop_active, len == 2);
   endtask

   // distance is the interval minimum plus off, at least one clock, from the command that really preceded
   task automatic pair(input logic rd, input int off, input logic [1:0] bg0,
                       input logic [1:0] bg1, input logic a0, input logic a1);
      int mn;
      int d;
      logic early;
      do_reset();
      if (rd)
         mn = int'(cas_latency) - int'(write_cas_latency) + read_burst_len(burst_mode, a0) / 2 + 1
              + (write_preamble_two_ck ? 2 : 1);
      else
         mn = int'(write_cas_latency) + write_burst_len(burst_mode) / 2
              + int'((bg0 == bg1) ? write_to_read_long : write_to_read_short);
      d = (mn + off < 1) ? 1 : mn + off;
      early = (d < mn) && dll_enabled && dll_locked && zq_extended_applied;
      if (d == 1)
         rwt_ctrl_model_inst.send_pair(rd, bg0, bg1, a0, a1);
      else
      begin
         rwt_ctrl_model_inst.send(rd, !rd, bg0, a0);
         repeat (d - 2) @(negedge clk_sys);
         rwt_ctrl_model_inst.send(!rd, rd, bg1, a1);
      end
      // the flag stands only in the cycle after the second command
      check("rd_to_wr_early", rd_to_wr_early, rd && early);
      check("wr_to_rd_early", wr_to_rd_early, !rd && early);
   endtask

   initial
   begin
      void'($urandom(32'ha8261c00));
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int m = 0; m < 4; m++)
         for (int a = 0; a < 2; a++)
         begin
            burst_mode = 2'(m);
            read_window(1'(a));
         end
      for (int g = 0; g < 3; g++)
      begin
         dll_enabled = (g != 0);
         dll_locked = (g != 1);
         zq_extended_applied = (g != 2);
         pair(1'b1, -4, 2'b01, 2'b01, 1'b1, 1'b1);
      end
      dll_enabled = 1'b1;
      dll_locked = 1'b1;
      zq_extended_applied = 1'b1;
      // back to back corners
      pair(1'b1, -40, 2'b00, 2'b11, 1'b1, 1'b1);
      pair(1'b0, -40, 2'b10, 2'b10, 1'b0, 1'b1);
      for (int i = 0; i < 150; i++)
      begin
         cas_latency = LAT_W'(9 + $urandom_range(15));
         write_cas_latency = cas_latency - LAT_W'($urandom_range(4));
         write_preamble_two_ck = 1'($urandom_range(1));
         write_to_read_long = WTR_W'(4 + $urandom_range(4));
         write_to_read_short = WTR_W'(2 + $urandom_range(2));
         burst_mode = 2'($urandom_range(3));
         read_window(1'($urandom_range(1)));
         pair(1'($urandom_range(1)), int'($urandom_range(2)) - 1, 2'($urandom_range(3)),
              2'($urandom_range(3)), 1'($urandom_range(1)), 1'($urandom_range(1)));
      end
      close_out();
   end
endmodule // rwt_turnaround_timer_test
